//--- shared/qb_port_defs.svh
`ifndef QB_PORT_DEFS_SVH
`define QB_PORT_DEFS_SVH

`define QB_PORT_WIDTH       8
`define QB_NUM_PORTS        5
`define QB_FIRST_PORT       3'h0
`define QB_THIRD_PORT       3'h2
`define QB_LATCH_RESET      8'hff
`define QB_PULLUP_RESET     1'b0
`define QB_STRONG_PU_CLKS   2

`endif

//--- shared/qb_port_pkg.sv
package qb_port_pkg;

    typedef enum logic [3:0] {
        OP_READ  = 4'h0,
        OP_WRITE = 4'h1,
        OP_ANL   = 4'h2,
        OP_ORL   = 4'h3,
        OP_XRL   = 4'h4,
        OP_INC   = 4'h5,
        OP_DEC   = 4'h6,
        OP_DJNZ  = 4'h7,
        OP_JBC   = 4'h8,
        OP_CPL   = 4'h9,
        OP_MOVB  = 4'ha,
        OP_CLR   = 4'hb,
        OP_SETB  = 4'hc
    } port_op_t;

    typedef struct packed {
        logic       valid;
        logic [2:0] port_sel;
        port_op_t   op;
        logic [2:0] bit_sel;
        logic [7:0] operand;
        logic       carry;
    } port_req_t;

    typedef struct packed {
        logic       valid;
        logic       err;
        logic       flag;
        logic [7:0] data;
    } port_rsp_t;

    typedef struct packed {
        logic       ok;
        logic       write;
        logic       flag;
        logic [7:0] val;
    } rmw_res_t;

endpackage : qb_port_pkg

//--- verilog/port_pin_cell.sv
`timescale 1ns/1ns
`default_nettype none
`include "qb_port_defs.svh"

module port_pin_cell #(
    parameter bit QUASI       = 1'b1,
    parameter int STRONG_CLKS = `QB_STRONG_PU_CLKS
) (
    input  wire logic       clk,
    input  wire logic       resetn,
    input  wire logic       pu_en,
    input  wire logic [7:0] latch,
    input  wire logic       bus_en,
    input  wire logic       bus_drive,
    input  wire logic [7:0] bus_val,
    input  wire logic [7:0] pin_in,
    output logic      [7:0] pin_sync,
    output logic      [7:0] pad_out,
    output logic      [7:0] pad_oe_n,
    output logic      [7:0] weak_pu,
    output logic      [7:0] vweak_pu
);
    localparam int CW = $clog2(STRONG_CLKS + 1);

    if (STRONG_CLKS < 1)
    begin : g_bad_clks
        $error("STRONG_CLKS must be at least 1");
    end

    logic [7:0]         meta_r;
    logic [7:0]         latch_d_r;
    logic [7:0][CW-1:0] cnt_r;
    logic [7:0][CW-1:0] cnt_nxt;
    logic [7:0]         out_nxt;
    logic [7:0]         oe_n_nxt;
    logic [7:0]         weak_nxt;
    logic [7:0]         vweak_nxt;
    wire logic          pu_on = QUASI | pu_en;

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchroniser, only the second stage is read
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            meta_r   <= 8'hff;
            pin_sync <= 8'hff;
        end
        else
        begin
            meta_r   <= pin_in;
            pin_sync <= meta_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Strong pull-up timer, started by a latch rising edge
    always_comb
    begin
        for (int i = 0; i < 8; i++)
        begin
            if (!latch[i] || !pu_on || bus_en)
                cnt_nxt[i] = '0;
            else if (!latch_d_r[i])
                cnt_nxt[i] = CW'(STRONG_CLKS);
            else if (cnt_r[i] != '0)
                cnt_nxt[i] = cnt_r[i] - CW'(1);
            else
                cnt_nxt[i] = cnt_r[i];
        end
    end

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            latch_d_r <= `QB_LATCH_RESET;
            cnt_r     <= '0;
        end
        else
        begin
            latch_d_r <= latch;
            cnt_r     <= cnt_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Pad drive and pull-up selection
    always_comb
    begin
        for (int i = 0; i < 8; i++)
        begin
            out_nxt[i]   = 1'b1;
            oe_n_nxt[i]  = 1'b1;
            weak_nxt[i]  = 1'b0;
            vweak_nxt[i] = 1'b0;
            if (bus_en)
            begin
                out_nxt[i]  = bus_val[i];
                oe_n_nxt[i] = ~bus_drive;
            end
            else if (!latch[i])
            begin
                out_nxt[i]  = 1'b0;
                oe_n_nxt[i] = 1'b0;
            end
            else
            begin
                oe_n_nxt[i]  = (cnt_nxt[i] == '0);
                vweak_nxt[i] = pu_on;
                weak_nxt[i]  = pu_on & pin_sync[i];
            end
        end
    end

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            pad_out  <= 8'hff;
            pad_oe_n <= 8'hff;
            weak_pu  <= 8'h00;
            vweak_pu <= 8'h00;
        end
        else
        begin
            pad_out  <= out_nxt;
            pad_oe_n <= oe_n_nxt;
            weak_pu  <= weak_nxt;
            vweak_pu <= vweak_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    for (genvar i = 0; i < 8; i++)
    begin : g_chk
        sequence s_rise;
            pu_on && !bus_en && latch[i] && !latch_d_r[i];
        endsequence
        sequence s_keep;
            pu_on && !bus_en && latch[i];
        endsequence

        a_strong_on: assert property (s_rise ##1 s_keep[*2]
            |-> !pad_oe_n[i] && pad_out[i] && $past(!pad_oe_n[i]))
            else $error("strong pull-up not held for two clocks");
        a_strong_off: assert property (s_rise ##1 s_keep[*3] |-> pad_oe_n[i])
            else $error("strong pull-up held too long");
        a_low_drive: assert property (!bus_en && !latch[i]
            |=> !pad_oe_n[i] && !pad_out[i])
            else $error("low latch not driven low");
        a_weak_follow: assert property (!bus_en && pu_on && latch[i]
            |=> weak_pu[i] == $past(pin_sync[i]) && vweak_pu[i])
            else $error("weak pull-up does not follow pin");
        a_open_drain: assert property (!bus_en && !pu_on && latch[i]
            |=> pad_oe_n[i] && !weak_pu[i] && !vweak_pu[i])
            else $error("open-drain bit not released");
        a_bus_drive: assert property (bus_en && bus_drive
            |=> !pad_oe_n[i] && pad_out[i] == $past(bus_val[i]))
            else $error("bus value not driven strongly");
    end

endmodule : port_pin_cell
`default_nettype wire

//--- verilog/quasi_bidir_port_control.sv
`timescale 1ns/1ns
`default_nettype none
`include "qb_port_defs.svh"

module quasi_bidir_port_control #(
    parameter int NUM_PORTS   = `QB_NUM_PORTS,
    parameter int STRONG_CLKS = `QB_STRONG_PU_CLKS
) (
    input  wire logic                        clk,
    input  wire logic                        resetn,
    input  wire qb_port_pkg::port_req_t      req,
    output qb_port_pkg::port_rsp_t           rsp,
    input  wire logic                        first_port_pullup_enable,
    input  wire logic                        ext_exec,
    input  wire logic                        ext_bus_active,
    input  wire logic                        ext_ad_drive,
    input  wire logic [7:0]                  ext_ad_out,
    input  wire logic [7:0]                  ext_addr_hi,
    output logic      [7:0]                  ext_ad_in,
    input  wire logic [NUM_PORTS-1:0][7:0]   pin_in,
    output logic      [NUM_PORTS-1:0][7:0]   pad_out,
    output logic      [NUM_PORTS-1:0][7:0]   pad_oe_n,
    output logic      [NUM_PORTS-1:0][7:0]   weak_pu,
    output logic      [NUM_PORTS-1:0][7:0]   vweak_pu
);
    if (NUM_PORTS < 3 || NUM_PORTS > 8)
    begin : g_bad_ports
        $error("NUM_PORTS must lie between 3 and 8");
    end

    logic [NUM_PORTS-1:0][7:0] latch_r;
    logic [NUM_PORTS-1:0][7:0] pin_sync;
    logic                      pu_r;
    logic [7:0]                sel_latch;
    logic [7:0]                sel_pin;
    logic                      sel_ok;
    logic                      accept;
    qb_port_pkg::rmw_res_t     res;

    ////////////////////////////////////////////////////////////////////////////
    // Helpers
    function automatic logic [7:0] put_bit(input logic [7:0] v, input logic [2:0] idx,
                                           input logic b);
        logic [7:0] r;
        r      = v;
        r[idx] = b;
        return r;
    endfunction : put_bit

    function automatic qb_port_pkg::rmw_res_t modify(input qb_port_pkg::port_op_t op,
                                                     input logic [7:0] lat,
                                                     input logic [7:0] pin,
                                                     input logic [7:0] opnd,
                                                     input logic [2:0] idx,
                                                     input logic       cy);
        qb_port_pkg::rmw_res_t r;
        r = '{ok: 1'b1, write: 1'b1, flag: 1'b0, val: lat};
        case (op)
            qb_port_pkg::OP_READ:
            begin
                r.write = 1'b0;
                r.val   = pin;
            end
            qb_port_pkg::OP_WRITE: r.val = opnd;
            qb_port_pkg::OP_ANL:   r.val = lat & opnd;
            qb_port_pkg::OP_ORL:   r.val = lat | opnd;
            qb_port_pkg::OP_XRL:   r.val = lat ^ opnd;
            qb_port_pkg::OP_INC:   r.val = lat + 8'h01;
            qb_port_pkg::OP_DEC:   r.val = lat - 8'h01;
            qb_port_pkg::OP_DJNZ:
            begin
                r.val  = lat - 8'h01;
                r.flag = (lat != 8'h01);
            end
            qb_port_pkg::OP_JBC:
            begin
                r.val  = put_bit(lat, idx, 1'b0);
                r.flag = lat[idx];
            end
            qb_port_pkg::OP_CPL:   r.val = put_bit(lat, idx, ~lat[idx]);
            qb_port_pkg::OP_MOVB:  r.val = put_bit(lat, idx, cy);
            qb_port_pkg::OP_CLR:   r.val = put_bit(lat, idx, 1'b0);
            qb_port_pkg::OP_SETB:  r.val = put_bit(lat, idx, 1'b1);
            default:
            begin
                r.ok    = 1'b0;
                r.write = 1'b0;
            end
        endcase
        return r;
    endfunction : modify

    ////////////////////////////////////////////////////////////////////////////
    // Request decode
    always_comb
    begin
        sel_latch = 8'hff;
        sel_pin   = 8'hff;
        sel_ok    = 1'b0;
        for (int k = 0; k < NUM_PORTS; k++)
        begin
            if (req.port_sel == 3'(k))
            begin
                sel_latch = latch_r[k];
                sel_pin   = pin_sync[k];
                sel_ok    = 1'b1;
            end
        end
        if (ext_exec && (req.port_sel == `QB_FIRST_PORT || req.port_sel == `QB_THIRD_PORT))
            sel_ok = 1'b0;
    end

    assign res    = modify(req.op, sel_latch, sel_pin, req.operand, req.bit_sel, req.carry);
    assign accept = req.valid && sel_ok && res.ok;

    ////////////////////////////////////////////////////////////////////////////
    // Output latches
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            latch_r <= {NUM_PORTS{`QB_LATCH_RESET}};
        else if (accept && res.write)
            latch_r[req.port_sel] <= res.val;
    end

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            pu_r <= `QB_PULLUP_RESET;
        else
            pu_r <= first_port_pullup_enable;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Response
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            rsp <= '0;
        else
        begin
            rsp.valid <= req.valid;
            rsp.err   <= req.valid && !accept;
            rsp.flag  <= accept && res.flag;
            rsp.data  <= accept ? res.val : 8'h00;
        end
    end

    assign ext_ad_in = pin_sync[0];

    ////////////////////////////////////////////////////////////////////////////
    // Pin cells: first port open-drain unless its pull-up is enabled, the others quasi-bidirectional
    for (genvar k = 0; k < NUM_PORTS; k++)
    begin : g_port
        port_pin_cell #(
            .QUASI       (k != 0),
            .STRONG_CLKS (STRONG_CLKS)
        ) u_cell (
            .clk       (clk),
            .resetn    (resetn),
            .pu_en     ((k == 0) ? pu_r : 1'b0),
            .latch     (latch_r[k]),
            .bus_en    ((k == 0 || k == 2) ? ext_bus_active : 1'b0),
            .bus_drive ((k == 0) ? ext_ad_drive : 1'b1),
            .bus_val   ((k == 0) ? ext_ad_out : ext_addr_hi),
            .pin_in    (pin_in[k]),
            .pin_sync  (pin_sync[k]),
            .pad_out   (pad_out[k]),
            .pad_oe_n  (pad_oe_n[k]),
            .weak_pu   (weak_pu[k]),
            .vweak_pu  (vweak_pu[k])
        );
    end

    ////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    sequence s_take(qb_port_pkg::port_op_t o);
        accept && req.op == o;
    endsequence

    a_rmw_latch: assert property (s_take(qb_port_pkg::OP_ANL)
        |=> latch_r[$past(req.port_sel)] == ($past(sel_latch) & $past(req.operand)))
        else $error("AND did not use the latch value");
    a_bit_only: assert property (s_take(qb_port_pkg::OP_SETB) or s_take(qb_port_pkg::OP_CLR)
        |=> ((latch_r[$past(req.port_sel)] ^ $past(sel_latch))
             & ~(8'h01 << $past(req.bit_sel))) == 8'h00)
        else $error("bit write changed another bit");
    a_read_pin: assert property (s_take(qb_port_pkg::OP_READ)
        |=> rsp.valid && !rsp.err && rsp.data == $past(sel_pin))
        else $error("plain read did not return pin level");
    a_refuse_bus: assert property (req.valid && ext_exec && req.port_sel == `QB_THIRD_PORT
        |=> rsp.err && $stable(latch_r))
        else $error("third port accessed during external execution");
    a_pu_follow: assert property (first_port_pullup_enable ##1 first_port_pullup_enable
        |=> pu_r && (vweak_pu[0] == $past(latch_r[0]) || $past(ext_bus_active)))
        else $error("first port pull-up not applied");

endmodule : quasi_bidir_port_control
`default_nettype wire

//--- dv/pin_world.sv
`timescale 1ns/1ns
`default_nettype none

module pin_world #(
    parameter int NUM_PORTS = 5
) (
    input  wire logic                      clk,
    input  wire logic [NUM_PORTS-1:0][7:0] pad_out,
    input  wire logic [NUM_PORTS-1:0][7:0] pad_oe_n,
    input  wire logic [NUM_PORTS-1:0][7:0] weak_pu,
    input  wire logic [NUM_PORTS-1:0][7:0] vweak_pu,
    input  wire logic [NUM_PORTS-1:0][7:0] drive_en,
    input  wire logic [NUM_PORTS-1:0][7:0] drive_val,
    input  wire logic [NUM_PORTS-1:0]      res_en,
    output logic      [NUM_PORTS-1:0][7:0] pin_in
);
    logic float_r = 1'b0;

    // A pad with nothing on it wanders from cycle to cycle
    always_ff @(posedge clk)
    begin
        float_r <= ~float_r;
    end

    // Strong pad drive wins, then external drivers, then any pull-up
    always_comb
    begin
        for (int p = 0; p < NUM_PORTS; p++)
        begin
            for (int b = 0; b < 8; b++)
            begin
                if (!pad_oe_n[p][b])
                    pin_in[p][b] = pad_out[p][b];
                else if (drive_en[p][b])
                    pin_in[p][b] = drive_val[p][b];
                else if (weak_pu[p][b] || vweak_pu[p][b] || res_en[p])
                    pin_in[p][b] = 1'b1;
                else
                    pin_in[p][b] = float_r ^ b[0];
            end
        end
    end
endmodule : pin_world
`default_nettype wire

//--- dv/tb_top.sv
`timescale 1ns/1ns
`default_nettype none

module tb_top;
    localparam int NP = 5;
    logic                   clk;
    logic                   resetn;
    qb_port_pkg::port_req_t req;
    qb_port_pkg::port_rsp_t rsp;
    logic                   pu_en;
    logic                   ext_exec;
    logic                   bus_act;
    logic                   ad_drive;
    logic [7:0]             ad_out;
    logic [7:0]             addr_hi;
    logic [7:0]             ad_in;
    logic [NP-1:0][7:0]     pin_in;
    logic [NP-1:0][7:0]     pad_out;
    logic [NP-1:0][7:0]     pad_oe_n;
    logic [NP-1:0][7:0]     weak_pu;
    logic [NP-1:0][7:0]     vweak_pu;
    logic [NP-1:0][7:0]     drive_en;
    logic [NP-1:0][7:0]     drive_val;
    logic [NP-1:0]          res_en;
    int                     errors;
    int                     n_compared;
    int                     cycles;

    quasi_bidir_port_control #(.NUM_PORTS(NP)) i_dut (
        .clk(clk), .resetn(resetn), .req(req), .rsp(rsp),
        .first_port_pullup_enable(pu_en), .ext_exec(ext_exec), .ext_bus_active(bus_act),
        .ext_ad_drive(ad_drive), .ext_ad_out(ad_out), .ext_addr_hi(addr_hi),
        .ext_ad_in(ad_in), .pin_in(pin_in), .pad_out(pad_out), .pad_oe_n(pad_oe_n),
        .weak_pu(weak_pu), .vweak_pu(vweak_pu)
    );

    pin_world #(.NUM_PORTS(NP)) i_world (
        .clk(clk), .pad_out(pad_out), .pad_oe_n(pad_oe_n), .weak_pu(weak_pu),
        .vweak_pu(vweak_pu), .drive_en(drive_en), .drive_val(drive_val),
        .res_en(res_en), .pin_in(pin_in)
    );

    ////////////////////////////////////////////////////////////////////////////////
    task automatic conclude();
        $display("compared %0d, mismatches %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : conclude

    task automatic cmp8(input logic [7:0] got, input logic [7:0] exp, input string what);
        n_compared++;
        if (got !== exp)
        begin
            errors++;
            $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask : cmp8

    task automatic cmp1(input logic got, input logic exp, input string what);
        n_compared++;
        if (got !== exp)
        begin
            errors++;
            $display("mismatch at %0t: %s got %b expected %b", $time, what, got, exp);
        end
    endtask : cmp1

    task automatic issue(input logic [2:0] port, input qb_port_pkg::port_op_t op,
                         input logic [2:0] bsel, input logic [7:0] opnd);
        req.port_sel = port;
        req.op = op;
        req.bit_sel = bsel;
        req.operand = opnd;
        req.carry = 1'b1;
        req.valid = 1'b1;
        @(posedge clk);
        #1;
    endtask : issue

    task automatic idle();
        req.valid = 1'b0;
        @(posedge clk);
        #1;
    endtask : idle

    task automatic settle();
        repeat (6) @(posedge clk);
        #1;
    endtask : settle

    // Latch after a modifying op, with the branch flag on top
    function automatic logic [8:0] ref_rmw(input qb_port_pkg::port_op_t op,
                                           input logic [7:0] lat, input logic [7:0] opnd,
                                           input logic [2:0] idx);
        logic [7:0] v;
        v = lat;
        case (op)
            qb_port_pkg::OP_ANL:  v = lat & opnd;
            qb_port_pkg::OP_ORL:  v = lat | opnd;
            qb_port_pkg::OP_XRL:  v = lat ^ opnd;
            qb_port_pkg::OP_INC:  v = lat + 8'h01;
            qb_port_pkg::OP_DEC,
            qb_port_pkg::OP_DJNZ: v = lat - 8'h01;
            qb_port_pkg::OP_CPL:  v[idx] = ~lat[idx];
            qb_port_pkg::OP_MOVB,
            qb_port_pkg::OP_SETB: v[idx] = 1'b1;
            default:              v[idx] = 1'b0;
        endcase
        return {(op == qb_port_pkg::OP_JBC) ? lat[idx] : (v != 8'h00), v};
    endfunction : ref_rmw

    ////////////////////////////////////////////////////////////////////////////////
    task automatic test_reset();
        settle();
        for (int p = 1; p < NP; p++)
        begin
            cmp8(pad_oe_n[p], 8'hff, "quasi oe_n");
            cmp8(vweak_pu[p], 8'hff, "quasi very weak");
            cmp8(weak_pu[p], 8'hff, "quasi weak");
        end
        cmp8(pad_oe_n[0], 8'hff, "first oe_n");
        cmp8(weak_pu[0] | vweak_pu[0], 8'h00, "first pull-ups");
        issue(3'h3, qb_port_pkg::OP_READ, 3'h0, 8'h00);
        cmp8(rsp.data, 8'hff, "reset read");
        idle();
        $display("test reset done");
    endtask : test_reset

    task automatic test_rmw();
        qb_port_pkg::port_op_t ops[11] = '{qb_port_pkg::OP_ANL, qb_port_pkg::OP_ORL,
            qb_port_pkg::OP_XRL, qb_port_pkg::OP_INC, qb_port_pkg::OP_DEC,
            qb_port_pkg::OP_DJNZ, qb_port_pkg::OP_JBC, qb_port_pkg::OP_CPL,
            qb_port_pkg::OP_MOVB, qb_port_pkg::OP_CLR, qb_port_pkg::OP_SETB};
        logic [7:0] opnds[11] = '{8'h3c, 8'h81, 8'hff, 0, 0, 0, 0, 0, 0, 0, 0};
        logic [2:0] bits[11] = '{0, 0, 0, 0, 0, 0, 3'h0, 3'h7, 3'h3, 3'h2, 3'h4};
        logic [7:0] lat;
        logic [8:0] exp;
        issue(3'h1, qb_port_pkg::OP_WRITE, 3'h0, 8'h5a);
        idle();
        drive_en[1] = 8'hf0;
        settle();
        issue(3'h1, qb_port_pkg::OP_READ, 3'h0, 8'h00);
        cmp8(rsp.data, 8'h0a, "pin read");
        lat = 8'h5a;
        for (int i = 0; i < 11; i++)
        begin
            exp = ref_rmw(ops[i], lat, opnds[i], bits[i]);
            issue(3'h1, ops[i], bits[i], opnds[i]);
            cmp1(rsp.valid & ~rsp.err, 1'b1, "rmw accepted");
            cmp8(rsp.data, exp[7:0], "rmw latch");
            if (ops[i] == qb_port_pkg::OP_JBC || ops[i] == qb_port_pkg::OP_DJNZ)
                cmp1(rsp.flag, exp[8], "rmw flag");
            lat = exp[7:0];
        end
        idle();
        settle();
        cmp8(pad_oe_n[1], lat, "strong low");
        cmp8(weak_pu[1], lat & 8'h0f, "weak follows pin");
        cmp8(vweak_pu[1], lat, "very weak follows latch");
        drive_en[1] = 8'h00;
        $display("test rmw done");
    endtask : test_rmw

    task automatic test_strong();
        issue(3'h4, qb_port_pkg::OP_WRITE, 3'h0, 8'h00);
        idle();
        settle();
        issue(3'h4, qb_port_pkg::OP_SETB, 3'h6, 8'h00);
        cmp8(rsp.data, 8'h40, "setb latch");
        idle();
        for (int k = 0; k < 3; k++)
        begin
            cmp8(pad_oe_n[4], (k < 2) ? 8'h00 : 8'h40, "strong pulse oe_n");
            cmp8(pad_out[4] & ~pad_oe_n[4], (k < 2) ? 8'h40 : 8'h00, "pulse level");
            @(posedge clk);
            #1;
        end
        $display("test strong done");
    endtask : test_strong

    task automatic test_first();
        res_en[0] = 1'b1;
        issue(3'h0, qb_port_pkg::OP_WRITE, 3'h0, 8'h00);
        idle();
        settle();
        cmp8(pad_oe_n[0] | pad_out[0], 8'h00, "open-drain low");
        issue(3'h0, qb_port_pkg::OP_WRITE, 3'h0, 8'hff);
        idle();
        cmp8(pad_oe_n[0], 8'hff, "no pulse");
        settle();
        cmp8(weak_pu[0] | vweak_pu[0], 8'h00, "no pull-ups");
        res_en[0] = 1'b0;
        pu_en = 1'b1;
        issue(3'h0, qb_port_pkg::OP_WRITE, 3'h0, 8'h00);
        idle();
        settle();
        issue(3'h0, qb_port_pkg::OP_WRITE, 3'h0, 8'hff);
        idle();
        cmp8(pad_oe_n[0], 8'h00, "quasi pulse");
        settle();
        cmp8(weak_pu[0], 8'hff, "pull-ups on");
        pu_en = 1'b0;
        $display("test first port done");
    endtask : test_first

    task automatic test_bus();
        bus_act = 1'b1;
        ad_drive = 1'b1;
        settle();
        cmp8(pad_oe_n[0] | pad_oe_n[2], 8'h00, "bus strong");
        cmp8(pad_out[0], 8'ha5, "bus data");
        cmp8(pad_out[2], 8'h3c, "bus address");
        ad_drive = 1'b0;
        drive_en[0] = 8'hff;
        ext_exec = 1'b1;
        settle();
        cmp8(ad_in, 8'h96, "bus read");
        issue(3'h0, qb_port_pkg::OP_READ, 3'h0, 8'h00);
        cmp1(rsp.err, 1'b1, "first port refused");
        issue(3'h2, qb_port_pkg::OP_WRITE, 3'h0, 8'h00);
        cmp1(rsp.err, 1'b1, "third port refused");
        issue(3'h3, qb_port_pkg::OP_ORL, 3'h0, 8'h00);
        cmp1(rsp.err, 1'b0, "other port served");
        issue(3'h3, qb_port_pkg::port_op_t'(4'hd), 3'h0, 8'h00);
        cmp1(rsp.err, 1'b1, "bad op refused");
        issue(3'h5, qb_port_pkg::OP_READ, 3'h0, 8'h00);
        cmp1(rsp.err, 1'b1, "bad port refused");
        idle();
        ext_exec = 1'b0;
        bus_act = 1'b0;
        drive_en[0] = 8'h00;
        settle();
        issue(3'h2, qb_port_pkg::OP_ORL, 3'h0, 8'h00);
        cmp8(rsp.data, 8'hff, "latch kept");
        idle();
        $display("test bus done");
    endtask : test_bus

    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            errors++;
            $display("mismatch at %0t: run timed out", $time);
            conclude();
        end
    end

    initial
    begin
        {errors, n_compared, cycles} = '0;
        resetn = 1'b0;
        req = '0;
        {pu_en, ext_exec, bus_act, ad_drive} = 4'h0;
        ad_out = 8'ha5;
        addr_hi = 8'h3c;
        drive_en = '0;
        drive_val = {8'h00, 8'h00, 8'h00, 8'h00, 8'h96};
        res_en = '0;
        repeat (3) @(posedge clk);
        #1;
        resetn = 1'b1;
        test_reset();
        test_rmw();
        test_strong();
        test_first();
        test_bus();
        conclude();
    end
endmodule : tb_top
`default_nettype wire
